// >>> hw/pfm_defines.svh
/*
  Offsets, reset values and fixed bit masks of the port function mux.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

// Register offsets, port 1
`define PFM_P1_IN      8'h00
`define PFM_P1_OUT     8'h04
`define PFM_P1_DIR     8'h08
`define PFM_P1_SEL     8'h0C
`define PFM_P1_IFG     8'h10
`define PFM_P1_IES     8'h14
`define PFM_P1_IE      8'h18
`define PFM_P1_IFGSET  8'h1C
// Register offsets, port 2
`define PFM_P2_IN      8'h20
`define PFM_P2_OUT     8'h24
`define PFM_P2_DIR     8'h28
`define PFM_P2_SEL     8'h2C
`define PFM_P2_IFG     8'h30
`define PFM_P2_IES     8'h34
`define PFM_P2_IE      8'h38
`define PFM_P2_IFGSET  8'h3C
// Register offsets, port 3
`define PFM_P3_IN      8'h40
`define PFM_P3_OUT     8'h44
`define PFM_P3_DIR     8'h48
`define PFM_P3_SEL     8'h4C

// Reset value of every control byte
`define PFM_RST_BYTE   8'h00
// Port 2 bits that have a pin
`define PFM_P2_PIN_MASK 8'h3F
// Bit positions used by the mux
`define PFM_BIT_SHCLK  3
`define PFM_BIT_TX     4
`define PFM_BIT_RX     5
// Edges after reset before edge detection: two sync stages and prev
`define PFM_PRIME_DEPTH 3

`endif

// >>> hw/pfm_irq_port.sv
/*
  Edge-triggered interrupt flags for one 8-bit port.
  Assumes sample is already synchronised to clk; software clear and set
  strobes come from the bus slave in the same clock domain.
*/
`include "pfm_defines.svh"
module pfm_irq_port
  import pfm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sample,
  input  wire logic [7:0] edge_select,
  input  wire logic [7:0] wr_clear,
  input  wire logic [7:0] wr_set,
  output logic      [7:0] pin_irq_flag
);

  logic [7:0] prev;
  logic [`PFM_PRIME_DEPTH-1:0] primed;
  logic [7:0] pin_edge;

  // Previous sample; detection waits until sync stages and prev hold the
  // real pin level, so a pin resting high gives no false edge after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev   <= `PFM_RST_BYTE;
      primed <= '0;
    end
    else
    begin
      prev   <= sample;
      primed <= {primed[`PFM_PRIME_DEPTH-2:0], 1'b1};
    end
  end

  // Rising edge when select clear, falling when set
  always_comb
  begin
    pin_edge = {8{primed[`PFM_PRIME_DEPTH-1]}} &
               ((edge_select & prev & ~sample) |
                (~edge_select & ~prev & sample)); // [R17]
  end

  // Sticky flags; a new edge or set wins over a clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pin_irq_flag <= `PFM_RST_BYTE;
    else
      pin_irq_flag <= (pin_irq_flag & ~wr_clear) | wr_set | pin_edge; // [R17]
  end

endmodule : pfm_irq_port

// >>> hw/pfm_pkg.sv
/*
  Types of the port function mux: pad bundles and module signal bundles.
  Assumes the defines header for all numeric constants.
*/
package pfm_pkg;

  // Drive of one 8-bit port towards its pads
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pfm_pad_s;

  // Per-port control bytes set by software
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] dir;
    logic [7:0] out;
  } pfm_ctl_s;

  // Compare levels coming from the general timer
  typedef struct packed {
    logic cmp0;
    logic cmp1;
    logic cmp2;
  } pfm_tmr_cmp_s;

  // Inputs routed to the general timer
  typedef struct packed {
    logic ext_clk;
    logic alt_clk;
    logic cap0_a;
    logic cap1_a;
    logic cap2_a;
    logic cap0_b;
  } pfm_tmr_in_s;

  // Signals coming from the serial unit
  typedef struct packed {
    logic tx;
    logic shclk_out;
    logic sync_mode;
    logic master;
  } pfm_ser_out_s;

  // Signals routed to the serial unit
  typedef struct packed {
    logic rx;
    logic shclk_in;
    logic ste;
  } pfm_ser_in_s;

endpackage : pfm_pkg

// >>> hw/pfm_port_mux.sv
/*
  Three 8-bit digital ports with per-pin function select, an APB register
  file and pin interrupts on ports 1 and 2.
  Assumes pad inputs are asynchronous, timer, clock, comparator and serial
  signals are on clk, and the pad cell resolves o/oe into the pin level.
*/
`include "pfm_defines.svh"
// What this block does
// [R1] P1.0 input feeds timer external clock
// [R2] P1.1-3 drive compares, feed captures A
// [R3] P1.4 drives sub main clock
// [R4] P1.5-7 drive compare levels zero..two
// [R5] P2.0 drives auxiliary clock
// [R6] P2.1 output low, input to alt clock
// [R7] P2.2 drives comparator, input capture 0B
// [R8] P2.3-4 drive compare levels one, two
// [R9] P2.5 output low, interrupts still present
// [R10] P2.6-7 flags change by software only
// [R11] P3.4 drives serial transmit, forced output
// [R12] P3.5 feeds serial receive, forced input
// [R13] Asynchronous serial mode: shift clock input
// [R14] Slave mode: partner supplies shift clock
// [R15] Master mode: device drives shift clock
// [R16] Select clear: latch and direction drive pin
// [R17] Chosen edge sets flag; enable requests
module pfm_port_mux
  import pfm_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  // Pads
  input  wire logic [7:0]        p1_pin_i,
  input  wire logic [7:0]        p2_pin_i,
  input  wire logic [7:0]        p3_pin_i,
  output pfm_pad_s               p1_pad,
  output pfm_pad_s               p2_pad,
  output pfm_pad_s               p3_pad,
  // On-chip modules
  input  wire logic              sub_main_clock,
  input  wire logic              auxiliary_clock,
  input  wire logic              comparator_result,
  input  pfm_tmr_cmp_s           tmr_cmp,
  input  pfm_ser_out_s           ser_out,
  output pfm_tmr_in_s            tmr_in,
  output pfm_ser_in_s            ser_in
);

  pfm_ctl_s   p1_ctl;
  pfm_ctl_s   p2_ctl;
  pfm_ctl_s   p3_ctl;
  logic [7:0] p1_ie;
  logic [7:0] p1_ies;
  logic [7:0] p2_ie;
  logic [7:0] p2_ies;
  logic [7:0] p1_flag;
  logic [7:0] p2_flag;
  logic [7:0] pin_meta [3];
  logic [7:0] input_sample [3];
  logic [7:0] p2_sample;
  logic       wr_en;
  logic [7:0] wbyte;
  logic [31:0] next_rdata;
  logic       next_err;
  logic [7:0] p1_mod_out;
  logic [7:0] p2_mod_out;
  logic [7:0] p3_mod_out;
  logic [7:0] p3_mod_dir;
  logic       shclk_drive;

  // Address match of an APB access
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  // Pad drive: latch path when select clear, module path when set
  function automatic pfm_pad_s pad_drive(input pfm_ctl_s   c,
                                         input logic [7:0] mod_out,
                                         input logic [7:0] mod_dir);
    pad_drive.o  = (c.sel & mod_out) | (~c.sel & c.out); // [R16]
    pad_drive.oe = (c.sel & mod_dir) | (~c.sel & c.dir); // [R16]
  endfunction : pad_drive

  // Two-stage synchroniser for every pad input
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_meta     <= '{default: `PFM_RST_BYTE};
      input_sample <= '{default: `PFM_RST_BYTE};
    end
    else
    begin
      pin_meta[0]     <= p1_pin_i;
      pin_meta[1]     <= p2_pin_i;
      pin_meta[2]     <= p3_pin_i;
      input_sample[0] <= pin_meta[0];
      input_sample[1] <= pin_meta[1];
      input_sample[2] <= pin_meta[2];
    end
  end

  // Port 2 bits 6 and 7 have no pad and never see an edge
  assign p2_sample = input_sample[1] & `PFM_P2_PIN_MASK; // [R10]

  // Write strobe at the completing access edge
  assign wr_en = psel & penable & pready & pwrite;
  assign wbyte = pwdata[7:0];

  // Control bytes of port 1
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      p1_ctl <= {3{`PFM_RST_BYTE}};
      p1_ie  <= `PFM_RST_BYTE;
      p1_ies <= `PFM_RST_BYTE;
    end
    else if (wr_en)
    begin
      if (hit(paddr, `PFM_P1_OUT)) p1_ctl.out <= wbyte;
      if (hit(paddr, `PFM_P1_DIR)) p1_ctl.dir <= wbyte;
      if (hit(paddr, `PFM_P1_SEL)) p1_ctl.sel <= wbyte;
      if (hit(paddr, `PFM_P1_IE))  p1_ie      <= wbyte;
      if (hit(paddr, `PFM_P1_IES)) p1_ies     <= wbyte;
    end
  end

  // Control bytes of port 2, edge select kept for all bits
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      p2_ctl <= {3{`PFM_RST_BYTE}};
      p2_ie  <= `PFM_RST_BYTE;
      p2_ies <= `PFM_RST_BYTE;
    end
    else if (wr_en)
    begin
      if (hit(paddr, `PFM_P2_OUT)) p2_ctl.out <= wbyte;
      if (hit(paddr, `PFM_P2_DIR)) p2_ctl.dir <= wbyte;
      if (hit(paddr, `PFM_P2_SEL)) p2_ctl.sel <= wbyte;
      if (hit(paddr, `PFM_P2_IE))  p2_ie      <= wbyte; // [R5] [R9]
      if (hit(paddr, `PFM_P2_IES)) p2_ies     <= wbyte; // [R5] [R9]
    end
  end

  // Control bytes of port 3
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      p3_ctl <= {3{`PFM_RST_BYTE}};
    else if (wr_en)
    begin
      if (hit(paddr, `PFM_P3_OUT)) p3_ctl.out <= wbyte;
      if (hit(paddr, `PFM_P3_DIR)) p3_ctl.dir <= wbyte;
      if (hit(paddr, `PFM_P3_SEL)) p3_ctl.sel <= wbyte;
    end
  end

  // Interrupt flags of port 1; P1.4 keeps its full set
  pfm_irq_port u_p1_irq (
    .clk          (clk),
    .rst_n        (rst_n),
    .sample       (input_sample[0]),
    .edge_select  (p1_ies),
    .wr_clear     ({8{wr_en & hit(paddr, `PFM_P1_IFG)}} & wbyte),
    .wr_set       ({8{wr_en & hit(paddr, `PFM_P1_IFGSET)}} & wbyte),
    .pin_irq_flag (p1_flag)
  ); // [R3] [R17]

  // Interrupt flags of port 2; upper bits are software sources
  pfm_irq_port u_p2_irq (
    .clk          (clk),
    .rst_n        (rst_n),
    .sample       (p2_sample),
    .edge_select  (p2_ies),
    .wr_clear     ({8{wr_en & hit(paddr, `PFM_P2_IFG)}} & wbyte),
    .wr_set       ({8{wr_en & hit(paddr, `PFM_P2_IFGSET)}} & wbyte),
    .pin_irq_flag (p2_flag)
  ); // [R10] [R17]

  // Read mux and unmapped-address detection
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    unique case (paddr[7:0])
      `PFM_P1_IN:     next_rdata[7:0] = input_sample[0];
      `PFM_P1_OUT:    next_rdata[7:0] = p1_ctl.out;
      `PFM_P1_DIR:    next_rdata[7:0] = p1_ctl.dir;
      `PFM_P1_SEL:    next_rdata[7:0] = p1_ctl.sel;
      `PFM_P1_IFG:    next_rdata[7:0] = p1_flag;
      `PFM_P1_IES:    next_rdata[7:0] = p1_ies;
      `PFM_P1_IE:     next_rdata[7:0] = p1_ie;
      `PFM_P1_IFGSET: next_rdata[7:0] = p1_flag;
      `PFM_P2_IN:     next_rdata[7:0] = p2_sample;
      `PFM_P2_OUT:    next_rdata[7:0] = p2_ctl.out;
      `PFM_P2_DIR:    next_rdata[7:0] = p2_ctl.dir;
      `PFM_P2_SEL:    next_rdata[7:0] = p2_ctl.sel;
      `PFM_P2_IFG:    next_rdata[7:0] = p2_flag;
      `PFM_P2_IES:    next_rdata[7:0] = p2_ies;
      `PFM_P2_IE:     next_rdata[7:0] = p2_ie;
      `PFM_P2_IFGSET: next_rdata[7:0] = p2_flag;
      `PFM_P3_IN:     next_rdata[7:0] = input_sample[2];
      `PFM_P3_OUT:    next_rdata[7:0] = p3_ctl.out;
      `PFM_P3_DIR:    next_rdata[7:0] = p3_ctl.dir;
      `PFM_P3_SEL:    next_rdata[7:0] = p3_ctl.sel;
      default:        next_err        = 1'b1;
    endcase
    if (paddr[ADDR_W-1:0] != ADDR_W'(paddr[7:0]))
    begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b1;
    end
  end

  // APB answer: one wait state, then ready; reset takes the idle branch
  always_ff @(posedge clk)
  begin
    if (rst_n && psel && penable && !pready)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end
    else
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Level interrupt while any enabled flag is set
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(p1_flag & p1_ie) | |(p2_flag & p2_ie); // [R17]
  end

  // Module output sources of port 1
  always_comb
  begin
    p1_mod_out    = `PFM_RST_BYTE;                    // [R1]
    p1_mod_out[1] = tmr_cmp.cmp0;                     // [R2]
    p1_mod_out[2] = tmr_cmp.cmp1;                     // [R2]
    p1_mod_out[3] = tmr_cmp.cmp2;                     // [R2]
    p1_mod_out[4] = sub_main_clock;                   // [R3]
    p1_mod_out[5] = tmr_cmp.cmp0;                     // [R4]
    p1_mod_out[6] = tmr_cmp.cmp1;                     // [R4]
    p1_mod_out[7] = tmr_cmp.cmp2;                     // [R4]
  end

  // Module output sources of port 2
  always_comb
  begin
    p2_mod_out    = `PFM_RST_BYTE;                    // [R6] [R9]
    p2_mod_out[0] = auxiliary_clock;                  // [R5]
    p2_mod_out[2] = comparator_result;                // [R7]
    p2_mod_out[3] = tmr_cmp.cmp1;                     // [R8]
    p2_mod_out[4] = tmr_cmp.cmp2;                     // [R8]
  end

  // Shift clock driven only in synchronous master mode
  assign shclk_drive = ser_out.sync_mode & ser_out.master; // [R13] [R15]

  // Module output sources and forced directions of port 3
  always_comb
  begin
    p3_mod_out                 = `PFM_RST_BYTE;
    p3_mod_dir                 = `PFM_RST_BYTE;       // [R12]
    p3_mod_out[`PFM_BIT_TX]    = ser_out.tx;          // [R11]
    p3_mod_dir[`PFM_BIT_TX]    = 1'b1;                // [R11]
    p3_mod_out[`PFM_BIT_SHCLK] = ser_out.shclk_out;   // [R15]
    p3_mod_dir[`PFM_BIT_SHCLK] = shclk_drive;         // [R13] [R14]
  end

  // Registered pad drive; ports 1 and 2 take direction from the latch
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      {p1_pad, p2_pad, p3_pad} <= '0;
    else
    begin
      p1_pad <= pad_drive(p1_ctl, p1_mod_out, p1_ctl.dir); // [R16]
      p2_pad <= pad_drive(p2_ctl, p2_mod_out, p2_ctl.dir); // [R16]
      p3_pad <= pad_drive(p3_ctl, p3_mod_out, p3_mod_dir); // [R16]
    end
  end

  // Inputs to the timer, gated by function select
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tmr_in <= '0;
    else
    begin
      tmr_in.ext_clk <= p1_ctl.sel[0] & input_sample[0][0]; // [R1]
      tmr_in.cap0_a  <= p1_ctl.sel[1] & input_sample[0][1]; // [R2]
      tmr_in.cap1_a  <= p1_ctl.sel[2] & input_sample[0][2]; // [R2]
      tmr_in.cap2_a  <= p1_ctl.sel[3] & input_sample[0][3]; // [R2]
      tmr_in.alt_clk <= p2_ctl.sel[1] & p2_sample[1];       // [R6]
      tmr_in.cap0_b  <= p2_ctl.sel[2] & p2_sample[2];       // [R7]
    end
  end

  // Inputs to the serial unit; receive idles high when deselected
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ser_in <= '0;
    else
    begin
      ser_in.rx       <= ~p3_ctl.sel[`PFM_BIT_RX] |
                         input_sample[2][`PFM_BIT_RX];      // [R12]
      ser_in.shclk_in <= p3_ctl.sel[`PFM_BIT_SHCLK] &
                         input_sample[2][`PFM_BIT_SHCLK];   // [R13] [R14]
      ser_in.ste      <= p3_ctl.sel[0] & input_sample[2][0];
    end
  end

endmodule : pfm_port_mux

// >>> tb/pfm_far_side.sv
/*
  Far side of the port mux: pad wires and on-chip module signals.
  Assumes the bench changes ext_oe, ext_val, ser_mode after rising edges.
*/
module pfm_far_side
  import pfm_pkg::*;
(
  input  wire logic        clk,
  input  pfm_pad_s         p1_pad,
  input  pfm_pad_s         p2_pad,
  input  pfm_pad_s         p3_pad,
  input  wire logic [23:0] ext_oe,
  input  wire logic [23:0] ext_val,
  input  wire logic [1:0]  ser_mode,
  output logic [7:0]       p1_pin_i,
  output logic [7:0]       p2_pin_i,
  output logic [7:0]       p3_pin_i,
  output logic             sub_main_clock,
  output logic             auxiliary_clock,
  output logic             comparator_result,
  output pfm_tmr_cmp_s     tmr_cmp,
  output pfm_ser_out_s     ser_out
);
  logic [4:0] cnt = 5'h00;

  // Free-running count makes the module clocks and levels
  always @(posedge clk)
    cnt <= cnt + 5'h01;

  // Device drive wins, else far side, else a pattern toggling each cycle
  function automatic logic [7:0] lvl(input pfm_pad_s p, input logic [7:0] oe,
                                     input logic [7:0] v, input logic t);
    return (p.oe & p.o) | (~p.oe & ((oe & v) | (~oe & {8{t}})));
  endfunction : lvl

  // Far party supplies the shift clock on P3.3 in slave mode
  assign p1_pin_i = lvl(p1_pad, ext_oe[7:0], ext_val[7:0], cnt[0]);
  assign p2_pin_i = lvl(p2_pad, ext_oe[15:8], ext_val[15:8], cnt[0]);
  assign p3_pin_i = lvl(p3_pad, ext_oe[23:16], ext_val[23:16], cnt[0]);
  assign sub_main_clock    = cnt[0];
  assign auxiliary_clock   = cnt[3];
  assign comparator_result = cnt[2];
  assign tmr_cmp           = cnt[3:1];
  assign ser_out           = {cnt[1], cnt[0], ser_mode};
endmodule : pfm_far_side

// >>> tb/pfm_port_mux_sva.sv
/*
  Port checker for the port function mux.
  Assumes control bytes change only by APB writes.
*/
module pfm_port_mux_sva
  import pfm_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input pfm_pad_s               p1_pad,
  input pfm_pad_s               p2_pad,
  input pfm_pad_s               p3_pad,
  input wire logic              sub_main_clock,
  input wire logic              auxiliary_clock,
  input wire logic              comparator_result,
  input pfm_tmr_cmp_s           tmr_cmp,
  input pfm_ser_out_s           ser_out
);
  logic [7:0] sh [0:19];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Shadow of the control bytes, taken where a write lands
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sh <= '{default: 8'h00};
    else if (psel && penable && pready && pwrite && !pslverr)
      sh[paddr[6:2]] <= pwdata[7:0];
  end

  // Access steps
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence

  a_ready_wait:
    assert property (s_setup |=> s_answer)
    else $error("pready not in second access cycle");
  a_ready_pulse:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_upper:
    assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("prdata upper bits set");
  a_sub_main_clock_drive:
    assert property ($past(sh[3][4] && sh[2][4]) |-> p1_pad.oe[4]
                     && p1_pad.o[4] == $past(sub_main_clock))
    else $error("P1.4 not driving sub main clock");
  a_gpio_latch:
    assert property (!$past(sh[3][0]) |-> p1_pad.oe[0] == $past(sh[2][0])
                     && (!p1_pad.oe[0] || p1_pad.o[0] == $past(sh[1][0])))
    else $error("P1.0 not following latch and direction");
  a_vss_output:
    assert property ($past(sh[11][1]) && p2_pad.oe[1] |-> !p2_pad.o[1])
    else $error("P2.1 module output not low");
  a_tx_forced:
    assert property ($past(sh[19][4]) |-> p3_pad.oe[4]
                     && p3_pad.o[4] == $past(ser_out.tx))
    else $error("P3.4 not driving transmit line");
  a_rx_forced:
    assert property ($past(sh[19][5]) |-> !p3_pad.oe[5])
    else $error("P3.5 not forced to input");
  a_shclk_dir:
    assert property ($past(sh[19][3]) |-> p3_pad.oe[3] ==
                     $past(ser_out.sync_mode && ser_out.master))
    else $error("P3.3 direction wrong for serial mode");
  a_p1_cmp_out:
    assert property ($past(sh[3][7:5] == 3'h7) |-> p1_pad.o[7:5] ==
                     $past({tmr_cmp.cmp2, tmr_cmp.cmp1, tmr_cmp.cmp0}))
    else $error("P1.5-7 not driving compare levels");
  a_p2_mod_out:
    assert property ($past(sh[11][4:2] == 3'h7 && sh[11][0]) |->
                     p2_pad.o[4:2] == $past({tmr_cmp.cmp2, tmr_cmp.cmp1,
                     comparator_result}) && p2_pad.o[0] ==
                     $past(auxiliary_clock))
    else $error("P2 module outputs not routed");
endmodule : pfm_port_mux_sva

bind pfm_port_mux pfm_port_mux_sva #(.ADDR_W(ADDR_W)) sva_u (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .p1_pad(p1_pad), .p2_pad(p2_pad),
  .p3_pad(p3_pad), .sub_main_clock(sub_main_clock),
  .auxiliary_clock(auxiliary_clock), .comparator_result(comparator_result),
  .tmr_cmp(tmr_cmp), .ser_out(ser_out));

// >>> tb/pfm_port_mux_tb.sv
/*
  Bench for the port function mux: APB tasks and directed tests.
  Assumes the far side model drives pins and module signals.
*/
`include "pfm_defines.svh"
module pfm_port_mux_tb
  import pfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h00000000;
  logic [31:0]  prdata, r;
  logic         pready, pslverr, irq, e;
  logic [23:0]  ext_oe = 24'hFFFFFF;
  logic [23:0]  ext_val = 24'h09060F;
  logic [1:0]   ser_mode = 2'b00;
  logic [7:0]   p1_pin_i, p2_pin_i, p3_pin_i;
  logic         sub_main_clock, auxiliary_clock, comparator_result;
  pfm_pad_s     p1_pad, p2_pad, p3_pad;
  pfm_tmr_cmp_s tmr_cmp;
  pfm_ser_out_s ser_out;
  pfm_tmr_in_s  tmr_in;
  pfm_ser_in_s  ser_in;
  int           mismatches = 0;
  int           n_checks = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  pfm_port_mux dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .p1_pin_i(p1_pin_i), .p2_pin_i(p2_pin_i), .p3_pin_i(p3_pin_i),
    .p1_pad(p1_pad), .p2_pad(p2_pad), .p3_pad(p3_pad),
    .sub_main_clock(sub_main_clock), .auxiliary_clock(auxiliary_clock),
    .comparator_result(comparator_result), .tmr_cmp(tmr_cmp),
    .ser_out(ser_out), .tmr_in(tmr_in), .ser_in(ser_in));

  pfm_far_side far_u (.clk(clk), .p1_pad(p1_pad), .p2_pad(p2_pad),
    .p3_pad(p3_pad), .ext_oe(ext_oe), .ext_val(ext_val),
    .ser_mode(ser_mode), .p1_pin_i(p1_pin_i), .p2_pin_i(p2_pin_i),
    .p3_pin_i(p3_pin_i), .sub_main_clock(sub_main_clock),
    .auxiliary_clock(auxiliary_clock),
    .comparator_result(comparator_result), .tmr_cmp(tmr_cmp),
    .ser_out(ser_out));

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n == 20)
      mismatches++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000, r, e);
    chk($sformatf("reg %h", a), x, r);
  endtask : rdc

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // Hang guard
  initial
  begin
    #20000;
    mismatches++;
    conclude();
  end

  // Directed tests
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 1; k < 20; k++)
      if (k % 8 != 0)
        rdc(8'(k * 4), 32'h00000000);
    apb(1'b0, 8'h50, 32'h00000000, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
    apb(1'b1, 8'h50, 32'h0000005A, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
    chk("tmr_in", 32'h00, 32'(tmr_in));
    chk("ser_in", 32'h4, 32'(ser_in));
    wr(`PFM_P1_DIR, 8'hFF);
    wr(`PFM_P1_OUT, 8'hA5);
    wt(2);
    chk("p1_pad", 32'hA5FF, 32'(p1_pad));
    rdc(`PFM_P1_IN, 32'hA5);
    wr(`PFM_P1_DIR, 8'h10);
    wr(`PFM_P1_SEL, 8'h1F);
    wr(`PFM_P2_SEL, 8'h26);
    wr(`PFM_P3_SEL, 8'h39);
    wt(5);
    chk("tmr_in", 32'h3F, 32'(tmr_in));
    chk("ser_in", 32'h3, 32'(ser_in));
    chk("p3_oe", 32'h10, {24'h0, p3_pad.oe});
    ser_mode <= 2'b11;
    wt(3);
    chk("p3_oe", 32'h18, {24'h0, p3_pad.oe});
    ser_mode <= 2'b10;
    ext_val[19] <= 1'b0;
    wt(5);
    chk("ser_in", 32'h1, 32'(ser_in));
    wr(`PFM_P2_DIR, 8'h22);
    wr(`PFM_P2_OUT, 8'h22);
    wt(2);
    chk("p2_pad", 32'h0022, 32'(p2_pad) & 32'h22FF);
    wr(`PFM_P1_IFG, 8'hFF);
    wr(`PFM_P2_IFG, 8'hFF);
    wr(`PFM_P1_IE, 8'h01);
    ext_val[0] <= 1'b0;
    wt(6);
    rdc(`PFM_P1_IFG, 32'h10);
    ext_val[0] <= 1'b1;
    wt(6);
    rdc(`PFM_P1_IFG, 32'h11);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`PFM_P1_IE, 8'h00);
    wt(2);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`PFM_P1_IFG, 8'h01);
    wr(`PFM_P1_IES, 8'h01);
    ext_val[0] <= 1'b0;
    wt(6);
    rdc(`PFM_P1_IFG, 32'h11);
    ext_val[15:14] <= 2'b11;
    wt(6);
    rdc(`PFM_P2_IFG, 32'h00);
    wr(`PFM_P2_IFGSET, 8'hC0);
    rdc(`PFM_P2_IFG, 32'hC0);
    wr(`PFM_P2_IE, 8'h80);
    wt(2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`PFM_P2_IFG, 8'hC0);
    wt(2);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`PFM_P1_SEL, 8'hFF);
    wr(`PFM_P2_SEL, 8'h3F);
    wt(3);
    chk("p2_oe", 32'h22, {24'h0, p2_pad.oe});
    conclude();
  end
endmodule : pfm_port_mux_tb
